// File: asl_pkg.sv
// package: constants, modes and register map of the axis stroke limit checker
package asl_pkg;
   localparam int unsigned POS_W          = 32;
   localparam logic [4:0]  ADDR_W         = 5'h08;
   // register byte offsets
   localparam logic [7:0]  OFF_CTRL       = 8'h00;
   localparam logic [7:0]  OFF_UPPER      = 8'h04;
   localparam logic [7:0]  OFF_LOWER      = 8'h08;
   localparam logic [7:0]  OFF_STATUS     = 8'h0C;
   localparam logic [7:0]  OFF_ERR        = 8'h10;
   localparam logic [7:0]  OFF_FEED       = 8'h14;
   // control field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_CHK_BIT   = 3;
   localparam int unsigned CTRL_DEG_BIT   = 4;
   localparam int unsigned CTRL_POSPH_BIT = 5;
   // reset values
   localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
   localparam logic [31:0] RST_UPPER      = 32'h7FFF_FFFF;
   localparam logic [31:0] RST_LOWER      = 32'h8000_0000;
   // minor error codes
   localparam logic [15:0] ERR_NONE       = 16'h0000;
   localparam logic [15:0] ERR_207        = 16'h00CF;
   localparam logic [15:0] ERR_208        = 16'h00D0;
   // control modes
   typedef enum logic [2:0] {
      ASL_MODE_FIXED, ASL_MODE_SPD1_CHK, ASL_MODE_SPD_NOCHK,
      ASL_MODE_SPDPOS, ASL_MODE_JOG, ASL_MODE_OTHER
   } asl_mode_e;
endpackage : asl_pkg

// File: asl_range_cmp.sv
// per-position stroke range comparator with direction permission
`timescale 1ns/1ps
module asl_range_cmp
   import asl_pkg::*;
(
   // operands
   input  wire logic signed [POS_W-1:0] pos_in,
   input  wire logic signed [POS_W-1:0] upper_in,
   input  wire logic signed [POS_W-1:0] lower_in,
   input  wire logic                    degree_in,
   // results
   output logic                         above_out,
   output logic                         below_out,
   output logic                         outside_out,
   output logic                         pos_ok_out,
   output logic                         neg_ok_out
);
   logic inverted;
   always_comb begin
      inverted  = degree_in && (upper_in < lower_in);
      above_out = pos_in > upper_in;
      below_out = pos_in < lower_in;
      if (inverted) begin
         // degree window wraps: inside is pos >= lower or pos <= upper
         outside_out = above_out && below_out;
         pos_ok_out  = 1'b1;
         neg_ok_out  = 1'b1;
      end else begin
         outside_out = above_out || below_out;
         pos_ok_out  = !above_out;
         neg_ok_out  = !below_out;
      end
   end
endmodule // asl_range_cmp

// File: asl_checker.sv
// axis stroke limit checker: wishbone registers and per-cycle supervision
`timescale 1ns/1ps
module asl_checker
   import asl_pkg::*;
(
   // clock and reset
   input  wire logic                    mclk_in,
   input  wire logic                    rstn_in,
   // wishbone slave
   input  wire logic                    wb_cyc_in,
   input  wire logic                    wb_stb_in,
   input  wire logic                    wb_we_in,
   input  wire logic [7:0]              wb_adr_in,
   input  wire logic [3:0]              wb_sel_in,
   input  wire logic [31:0]             wb_dat_in,
   output logic [31:0]                  wb_dat_out,
   output logic                         wb_ack_out,
   // motion core
   input  wire logic                    cycle_tick_in,
   input  wire logic signed [POS_W-1:0] feed_pos_in,
   input  wire logic signed [POS_W-1:0] stop_pos_in,
   input  wire logic                    start_req_in,
   input  wire logic signed [POS_W-1:0] target_in,
   input  wire logic                    dir_neg_in,
   // external pins
   input  wire logic                    upper_limit_input_in,
   input  wire logic                    lower_limit_input_in,
   input  wire logic                    stop_input_in,
   // reactions
   output logic                         start_ok_out,
   output logic                         start_reject_out,
   output logic                         decel_stop_out,
   output logic                         immed_stop_out,
   output logic                         zero_feed_out,
   output logic [15:0]                  minor_err_out
);
   import asl_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0]             ctrl_q;
   logic signed [POS_W-1:0] upper_q;
   logic signed [POS_W-1:0] lower_q;
   logic [15:0]             err_q;
   logic signed [POS_W-1:0] feed_q;
   logic                    wb_req;
   logic                    err_clr;
   logic [31:0]             rd_d;
   asl_mode_e               mode;
   logic                    chk_en;
   logic                    degree;
   logic                    pos_phase;
   logic                    outside_f;

   assign wb_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign mode      = asl_mode_e'(ctrl_q[CTRL_MODE_LSB +: 3]);
   assign chk_en    = ctrl_q[CTRL_CHK_BIT];
   assign degree    = ctrl_q[CTRL_DEG_BIT];
   assign pos_phase = ctrl_q[CTRL_POSPH_BIT];
   assign err_clr   = wb_req && wb_we_in && (wb_adr_in == OFF_ERR)
                      && wb_sel_in[0];

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_q  <= RST_CTRL;
         upper_q <= RST_UPPER;
         lower_q <= RST_LOWER;
      end else if (wb_req && wb_we_in) begin
         case (wb_adr_in)
            OFF_CTRL:  ctrl_q  <= merge(ctrl_q, wb_dat_in, wb_sel_in);
            OFF_UPPER: upper_q <= merge(upper_q, wb_dat_in, wb_sel_in);
            OFF_LOWER: lower_q <= merge(lower_q, wb_dat_in, wb_sel_in);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wishbone answer: one registered ack the cycle after the request, unmapped reads give zero
   always_comb begin
      rd_d = 32'h0000_0000;
      case (wb_adr_in)
         OFF_CTRL:   rd_d = ctrl_q;
         OFF_UPPER:  rd_d = upper_q;
         OFF_LOWER:  rd_d = lower_q;
         OFF_STATUS: rd_d = {26'h0, zero_feed_out, immed_stop_out,
                             decel_stop_out, start_reject_out,
                             start_ok_out, outside_f};
         OFF_ERR:    rd_d = {16'h0000, err_q};
         OFF_FEED:   rd_d = feed_q;
         default:    rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= wb_req;
         if (wb_req && !wb_we_in) begin
            wb_dat_out <= rd_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         pin_s1_q <= {stop_input_in, lower_limit_input_in,
                      upper_limit_input_in};
         pin_s2_q <= pin_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // comparisons: feed, predicted stop point, start target
   logic above_f, below_f, pos_ok_f, neg_ok_f;
   logic above_s, below_s, outside_s;
   logic outside_t;
   logic pos_ok_s, neg_ok_s, pos_ok_t, neg_ok_t;

   asl_range_cmp u_cmp_feed (
      .pos_in      (feed_pos_in),
      .upper_in    (upper_q),
      .lower_in    (lower_q),
      .degree_in   (degree),
      .above_out   (above_f),
      .below_out   (below_f),
      .outside_out (outside_f),
      .pos_ok_out  (pos_ok_f),
      .neg_ok_out  (neg_ok_f)
   );

   asl_range_cmp u_cmp_stop (
      .pos_in      (stop_pos_in),
      .upper_in    (upper_q),
      .lower_in    (lower_q),
      .degree_in   (degree),
      .above_out   (above_s),
      .below_out   (below_s),
      .outside_out (outside_s),
      .pos_ok_out  (pos_ok_s),
      .neg_ok_out  (neg_ok_s)
   );

   asl_range_cmp u_cmp_tgt (
      .pos_in      (target_in),
      .upper_in    (upper_q),
      .lower_in    (lower_q),
      .degree_in   (degree),
      .above_out   (),
      .below_out   (),
      .outside_out (outside_t),
      .pos_ok_out  (pos_ok_t),
      .neg_ok_out  (neg_ok_t)
   );

   ////////////////////////////////////////////////////////////////////
   // start qualification
   logic        dir_ok;
   logic        checking;
   logic [15:0] fix_code;
   logic        fix_pend_q;
   always_comb begin
      dir_ok   = dir_neg_in ? neg_ok_f : pos_ok_f;
      // target past the upper side reports 208, past the lower side 207
      fix_code = ERR_NONE;
      if (start_req_in && mode == ASL_MODE_FIXED && outside_t) begin
         fix_code = pos_ok_t ? ERR_207 : ERR_208;
      end
      case (mode)
         ASL_MODE_SPD1_CHK: checking = chk_en;
         ASL_MODE_SPDPOS:   checking = pos_phase;
         ASL_MODE_FIXED:    checking = 1'b1;
         ASL_MODE_JOG:      checking = 1'b1;
         default:           checking = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         start_ok_out     <= 1'b0;
         start_reject_out <= 1'b0;
      end else begin
         start_ok_out     <= 1'b0;
         start_reject_out <= 1'b0;
         if (start_req_in) begin
            if (mode == ASL_MODE_FIXED && outside_t) begin
               start_reject_out <= 1'b1;
            end else if (checking && outside_f && !dir_ok) begin
               start_reject_out <= 1'b1;
            end else begin
               start_ok_out     <= 1'b1;
            end
         end
      end
   end

   // a start pulse seldom meets the tick, so its decel waits for it here
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fix_pend_q <= 1'b0;
      end else if (cycle_tick_in) begin
         fix_pend_q <= 1'b0;
      end else if (fix_code != ERR_NONE) begin
         fix_pend_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per control cycle supervision
   logic        decel_d, immed_d, zero_d;
   logic [15:0] err_d;
   always_comb begin
      decel_d = 1'b0;
      immed_d = 1'b0;
      zero_d  = 1'b0;
      err_d   = ERR_NONE;
      case (mode)
         ASL_MODE_FIXED: begin
            if (fix_pend_q || fix_code != ERR_NONE) begin
               decel_d = 1'b1;
            end
         end
         ASL_MODE_SPD1_CHK: begin
            if (!chk_en) begin
               zero_d  = 1'b1;
               decel_d = |pin_s2_q;
            end else if (outside_f) begin
               decel_d = 1'b1;
            end
         end
         ASL_MODE_SPD_NOCHK: begin
            zero_d  = 1'b1;
            decel_d = |pin_s2_q;
         end
         ASL_MODE_SPDPOS: begin
            if (pos_phase && outside_s) begin
               decel_d = 1'b1;
               err_d   = ERR_207;
            end
         end
         ASL_MODE_JOG: begin
            if (outside_f && !(dir_neg_in ? neg_ok_f : pos_ok_f)) begin
               immed_d = 1'b1;
               err_d   = ERR_207;
            end
         end
         default: ;
      endcase
   end

   // outputs refresh only on the control cycle tick, then hold
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         decel_stop_out <= 1'b0;
         immed_stop_out <= 1'b0;
         zero_feed_out  <= 1'b0;
         feed_q         <= '0;
      end else if (cycle_tick_in) begin
         decel_stop_out <= decel_d;
         immed_stop_out <= immed_d;
         zero_feed_out  <= zero_d;
         feed_q         <= zero_d ? '0 : feed_pos_in;
      end
   end

   // sticky error code: a new error wins over a software clear
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         err_q         <= ERR_NONE;
         minor_err_out <= ERR_NONE;
      end else begin
         if (fix_code != ERR_NONE) begin
            err_q <= fix_code;
         end else if (cycle_tick_in && err_d != ERR_NONE) begin
            err_q <= err_d;
         end else if (err_clr) begin
            err_q <= ERR_NONE;
         end
         minor_err_out <= err_q;
      end
   end
endmodule // asl_checker

// File: asl_checker_properties.sv
// port-level assertions for the axis stroke limit checker
`timescale 1ns/1ps
module asl_props (
   // clock and reset
   input  wire logic mclk_in,
   input  wire logic rstn_in,
   // bus handshake
   input  wire logic wb_cyc_in,
   input  wire logic wb_stb_in,
   input  wire logic wb_ack_out,
   // motion core
   input  wire logic cycle_tick_in,
   input  wire logic start_req_in,
   // reactions
   input  wire logic start_ok_out,
   input  wire logic start_reject_out,
   input  wire logic decel_stop_out,
   input  wire logic immed_stop_out,
   input  wire logic zero_feed_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   ////////////////////////////////////////////////////////////////////////
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_ack;
      wb_ack_out ##1 !wb_ack_out;
   endsequence
   AST_ACK_WALK: assert property (s_req |=> s_ack)
      else $error("bus request not acked for exactly one cycle");
   AST_START_ANS: assert property (
      start_req_in |=> (start_ok_out != start_reject_out))
      else $error("start request not answered once");
   AST_OK_CAUSE: assert property (
      start_ok_out |-> $past(start_req_in))
      else $error("start accepted without a request");
   AST_REJ_CAUSE: assert property (
      start_reject_out |-> $past(start_req_in))
      else $error("start refused without a request");
   // stop and zero feed reactions may only move on a control cycle boundary
   AST_DECEL_TICK: assert property (
      $changed(decel_stop_out) |-> $past(cycle_tick_in))
      else $error("decel stop changed off the control cycle");
   AST_IMMED_TICK: assert property (
      $changed(immed_stop_out) |-> $past(cycle_tick_in))
      else $error("immediate stop changed off the control cycle");
   AST_ZERO_TICK: assert property (
      $changed(zero_feed_out) |-> $past(cycle_tick_in))
      else $error("zero feed changed off the control cycle");
   AST_NO_RAMP: assert property (
      immed_stop_out |-> !decel_stop_out)
      else $error("immediate stop came with a ramp");
endmodule // asl_props

bind asl_checker asl_props u_props (.mclk_in(mclk_in), .rstn_in(rstn_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
   .cycle_tick_in(cycle_tick_in), .start_req_in(start_req_in),
   .start_ok_out(start_ok_out), .start_reject_out(start_reject_out),
   .decel_stop_out(decel_stop_out), .immed_stop_out(immed_stop_out),
   .zero_feed_out(zero_feed_out));

// File: asl_motion_model.sv
// motion core stand-in: control cycle, feed value and stop point
`timescale 1ns/1ps
module asl_motion_model (
   // clock and reset
   input  wire logic                             mclk_in,
   input  wire logic                             rstn_in,
   // bench control
   input  wire logic                             load_in,
   input  wire logic signed [asl_pkg::POS_W-1:0] load_pos_in,
   input  wire logic signed [asl_pkg::POS_W-1:0] vel_in,
   // device reactions
   input  wire logic                             decel_stop_in,
   input  wire logic                             immed_stop_in,
   // feed outputs
   output logic                                  cycle_tick_out,
   output logic signed [asl_pkg::POS_W-1:0]      feed_pos_out,
   output logic signed [asl_pkg::POS_W-1:0]      stop_pos_out
);
   logic [1:0] div_q;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in)
         div_q <= 2'h0;
      else
         div_q <= div_q + 2'h1;
   end
   assign cycle_tick_out = (div_q == 2'h3);
   // axis freezes on any stop so the bench sees a settled position
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in)
         feed_pos_out <= '0;
      else if (load_in)
         feed_pos_out <= load_pos_in;
      else if (cycle_tick_out && !decel_stop_in && !immed_stop_in)
         feed_pos_out <= feed_pos_out + vel_in;
   end
   // braking distance taken as four control cycles of travel
   assign stop_pos_out = feed_pos_out + (vel_in <<< 2);
endmodule // asl_motion_model

// File: testbench.sv
// self-checking bench for the axis stroke limit checker
`timescale 1ns/1ps
module testbench;
   import asl_pkg::*;
   logic               mclk_in = 0, rstn_in = 0;
   logic               cyc = 0, stb = 0, we = 0, go = 0, dn = 0, ld = 0;
   logic               ack, tick, ok, rej, dec, imm, zro, o, p, k, z;
   logic [7:0]         adr = '0, c;
   logic [2:0]         m;
   logic [2:0]         pins = '0;
   logic [31:0]        wd = '0, rd, rv;
   logic [15:0]        err;
   logic signed [31:0] tgt = '0, lp = '0, vel = '0, feed, spos;
   int fail_count = 0, check_count = 0, seed = 16507, t, e;
   logic [7:0]  ra[6] = '{OFF_CTRL, OFF_UPPER, OFF_LOWER, OFF_ERR,
                          OFF_STATUS, 8'h1C};
   logic [31:0] rx[6] = '{RST_CTRL, RST_UPPER, RST_LOWER, 0, 0, 0};
   int ups[3] = '{100, 100, -100}, los[3] = '{-100, -100, 100};
   int ps[3] = '{150, -150, 0}, tg[3] = '{0, 0, 150};
   int sc[7] = '{9, 1, 2, 3, 35, 4, 9}, sv[7] = '{5, 5, 5, 5, 5, 5, 2};
   always #4 mclk_in = ~mclk_in;
   asl_checker DUT (.mclk_in, .rstn_in, .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd),
      .wb_dat_out(rd), .wb_ack_out(ack), .cycle_tick_in(tick),
      .feed_pos_in(feed), .stop_pos_in(spos), .start_req_in(go),
      .target_in(tgt), .dir_neg_in(dn), .upper_limit_input_in(pins[0]),
      .lower_limit_input_in(pins[1]), .stop_input_in(pins[2]),
      .start_ok_out(ok),
      .start_reject_out(rej), .decel_stop_out(dec), .immed_stop_out(imm),
      .zero_feed_out(zro), .minor_err_out(err));
   asl_motion_model PM (.mclk_in, .rstn_in, .load_in(ld), .load_pos_in(lp),
      .vel_in(vel), .decel_stop_in(dec), .immed_stop_in(imm),
      .cycle_tick_out(tick), .feed_pos_out(feed), .stop_pos_out(spos));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string s, logic [31:0] ex, logic [31:0] g);
      check_count++;
      if (g !== ex) begin
         fail_count++;
         $display("[FAIL] %s exp %h got %h", s, ex, g);
      end
   endtask
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int n = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge mclk_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n == 20) fail_count++;
      rv = rd;
      cyc <= 0;
      stb <= 0;
      @(posedge mclk_in);
   endtask
   task automatic rst();
      rstn_in <= 0;
      repeat (4) @(posedge mclk_in);
      rstn_in <= 1;
      @(posedge mclk_in);
   endtask
   task automatic place(int pos, int u, int l, logic [7:0] cv);
      vel <= 0;
      dn <= 0;
      lp <= pos;
      ld <= 1;
      @(posedge mclk_in);
      ld <= 0;
      wb(1, OFF_UPPER, u);
      wb(1, OFF_LOWER, l);
      wb(1, OFF_CTRL, {24'h0, cv});
   endtask
   task automatic start(int tv, logic d);
      go <= 1;
      tgt <= tv;
      dn <= d;
      @(posedge mclk_in);
      go <= 0;
      @(posedge mclk_in);
   endtask
   // outside an inverted range both ways lead back in
   function automatic logic dir_ok(int u, int l, int pos, logic d);
      if (u < l) return 1'b1;
      if (pos > u) return d;
      if (pos < l) return !d;
      return 1'b1;
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst();
      wb(1, OFF_STATUS, 32'hFFFF_FFFF);
      wb(1, 8'h1C, 32'hA5A5_A5A5);
      for (int i = 0; i < 6; i++) begin
         wb(0, ra[i], 0);
         chk("reg read", rx[i], rv);
      end
      $display("test registers done");
      place(0, 100, -100, 8'h00);
      for (int i = 0; i < 10; i++) begin
         t = $random(seed) % 200;
         if (i < 2) t = i ? -101 : 100;
         e = (t > 100) ? 208 : (t < -100) ? 207 : 0;
         wb(1, OFF_ERR, 0);
         start(t, t < 0);
         chk("start ok", e == 0, ok);
         chk("start reject", e != 0, rej);
         wb(0, OFF_ERR, 0);
         chk("err reg", e, rv);
         chk("err pin", e, err);
      end
      $display("test fixed pitch done");
      for (int i = 0; i < 6; i++) begin
         place(ps[i/2], ups[i/2], los[i/2], 8'h10);
         start(tg[i/2], i[0]);
         e = dir_ok(ups[i/2], los[i/2], ps[i/2], i[0]);
         chk("dir ok", e, ok);
      end
      $display("test direction done");
      for (int i = 0; i < 7; i++) begin
         rst();
         place(i == 6 ? 80 : 90, 100, -100, sc[i][7:0]);
         vel <= sv[i];
         repeat (32) @(posedge mclk_in);
         c = sc[i][7:0];
         m = c[2:0];
         o = feed > 100 || feed < -100;
         p = spos > 100 || spos < -100;
         k = m == 3 && c[5];
         z = m == 2 || (m == 1 && !c[3]);
         chk("decel", (m == 1 && c[3] && o) || (k && p), dec);
         chk("immed", m == 4 && o, imm);
         chk("zero", z, zro);
         wb(0, OFF_ERR, 0);
         chk("err", ((m == 4 && o) || (k && p)) ? 207 : 0, rv);
         wb(0, OFF_FEED, 0);
         if (z) begin
            chk("feed reg", 0, rv);
            pins <= {i[1], i[0], 1'b1};
            repeat (8) @(posedge mclk_in);
            chk("limit pin decel", 1, dec);
            pins <= 3'h0;
         end
      end
      $display("test supervision done");
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge mclk_in);
      fail_count++;
      stop_test();
   end
endmodule // testbench
